//--- inc/fwm_pkg.sv
// fault and warning manager: constants, configuration and state types
// assumes a 20 MHz system clock and a 32-bit APB register port
package fwm_pkg;
	// register byte offsets
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [7:0] A_CMD = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_GRP0 = 8'h0C;
	localparam logic [7:0] A_LCNT = 8'h20;
	localparam logic [7:0] A_LIDX = 8'h24;
	localparam logic [7:0] A_LDAT = 8'h28;
	localparam logic [7:0] A_LACK = 8'h2C;
	localparam int CMD_RST_BIT = 7;
	localparam int NGRP = 5;
	localparam int NWARN = 3;
	localparam int W_EXT = 0;
	localparam int W_SUP = 1;
	localparam int W_LOG = 2;
	localparam int F_EXT = 0;
	localparam int F_SUP = 1;
	localparam int F_OVL = 2;
	localparam int F_GEN = 3;
	// security log
	localparam logic [8:0] LOG_DEPTH = 9'd500;
	localparam logic [8:0] LOG_WARN_LVL = 9'd450;
	localparam logic [8:0] LOG_DROP = 9'd50;
	localparam logic [7:0] ADMIN_ID = 8'h00;
	// timing: one second tick, limits in minutes
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_SEC = 1;
	localparam int SEC_CYCLES = CLK_HZ * TICK_SEC;
	localparam int SEC_PER_MIN = 60;
	localparam int T_5MIN = 5;
	localparam int T_10MIN = 10;
	localparam int T_30MIN = 30;
	localparam int T_1H_MIN = 60;
	localparam int T_2H_MIN = 120;
	localparam int T_3H_MIN = 180;

	typedef enum logic [1:0] {EXT_IGNORE, EXT_FREEWHEEL, EXT_CFG_STOP, EXT_DECEL} fwm_ext_t;
	typedef enum logic [1:0] {SUP_ERROR, SUP_ERR_NO_RELAY, SUP_WARNING, SUP_RSVD} fwm_sup_t;
	typedef enum logic [1:0] {RST_NONE, RST_DI, RST_CMD, RST_RSVD} fwm_rsrc_t;

	typedef struct packed {
		logic access_ctrl;
		logic relay_fault_map;
		logic three_wire;
		fwm_sup_t supply_loss_response;
		fwm_rsrc_t manual_reset_source;
		logic [2:0] auto_reset_time_limit;
		logic auto_reset_enable;
		fwm_ext_t ext_fault_response;
		logic ext_level_low;
		logic [1:0] ext_fault_source;
	} fwm_cfg_t;

	// freewheel response, 5 minute limit, relay mapped to fault state
	localparam fwm_cfg_t CFG_RST = 16'h4008;

	typedef struct packed {
		logic drive_off;
		logic stop_req;
		logic decel_req;
		logic fault_state;
		logic fault_relay;
		logic [NGRP-1:0] warn_relay;
		logic warn_led;
		logic restart;
	} fwm_out_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} fwm_apb_t;

	typedef struct packed {
		fwm_cfg_t cfg;
		logic [NGRP-1:0][NWARN-1:0] grp;
		logic [3:0] flt;
		logic decel_pend;
		logic rst_di_q;
		logic run_q;
		logic [24:0] tick;
		logic [13:0] sec;
		logic expired;
		logic [8:0] lhead;
		logic [8:0] ltail;
		logic [8:0] lcnt;
		logic [8:0] lidx;
		logic lwarn;
		fwm_out_t o;
		fwm_apb_t b;
	} fwm_st_t;

	localparam fwm_st_t ST_RST = '{cfg: CFG_RST, o: '{fault_relay: 1'b1, default: '0},
		default: '0};

	// limit in seconds, zero means unlimited
	function automatic logic [13:0] limit_sec(input logic [2:0] sel);
		int m;
		unique case (sel)
			3'd0: m = T_5MIN;
			3'd1: m = T_10MIN;
			3'd2: m = T_30MIN;
			3'd3: m = T_1H_MIN;
			3'd4: m = T_2H_MIN;
			3'd5: m = T_3H_MIN;
			default: m = 0;
		endcase
		return 14'(m * SEC_PER_MIN);
	endfunction
endpackage

//--- rtl/fwm_top.sv
// fault and warning manager of a motor soft starter, APB register port
// inputs are synchronous to ref_clk; outputs are all registered
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fwm_top import fwm_pkg::*; #(
	parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external error inputs, one per assignable source
	input wire logic [2:0] ext_in,
	// reset and run orders
	input wire logic reset_di,
	input wire logic run_order,
	// motor and supply status
	input wire logic motor_running,
	input wire logic decel_done,
	input wire logic supply_ok,
	input wire logic overload_in,
	input wire logic gen_fault_in,
	// security events
	input wire logic sec_evt_valid,
	input wire logic [7:0] sec_evt_code,
	input wire logic [7:0] sec_evt_user,
	// motor control and relays
	output logic drive_off,
	output logic stop_req,
	output logic decel_req,
	output logic fault_state_out,
	output logic fault_relay,
	output logic [NGRP-1:0] warn_relay,
	output logic warn_led,
	output logic restart_pulse
);
	fwm_st_t s, n;
	logic [15:0] log_mem [0:LOG_DEPTH-1];
	logic log_we;
	logic [15:0] log_wdata;

	// group mask registers sit one word apart, starting at the first group
	function automatic logic grp_hit(input logic [7:0] a, input int g);
		return a == 8'(A_GRP0 + 8'(4 * g));
	endfunction

	function automatic logic [8:0] wrap_add(input logic [8:0] a, input logic [8:0] b);
		logic [9:0] t;
		t = {1'b0, a} + {1'b0, b};
		if (t >= {1'b0, LOG_DEPTH}) begin
			t = t - {1'b0, LOG_DEPTH};
		end
		return t[8:0];
	endfunction

	always_comb begin
		logic ext_det;
		logic sup_bad;
		logic man_rst;
		logic cmd_rst;
		logic lack;
		logic [3:0] cause;
		logic [3:0] fset;
		logic [NWARN-1:0] warn;
		logic [NWARN-1:0] grouped;
		logic [13:0] lim;
		logic faulted;
		logic sup_only;
		n = s;
		ext_det = 1'b0;
		man_rst = 1'b0;
		cmd_rst = 1'b0;
		lack = 1'b0;
		fset = '0;
		warn = '0;
		grouped = '0;
		sup_bad = 1'b0;
		cause = '0;
		lim = '0;
		faulted = 1'b0;
		sup_only = 1'b0;
		log_we = 1'b0;
		log_wdata = '0;
		n.o.restart = 1'b0;
		n.o.stop_req = 1'b0;
		for (int g = 0; g < NGRP; g++) begin
			grouped = grouped | s.grp[g];
		end
		// apb: answer one cycle into the access phase
		n.b.pready = 1'b0;
		n.b.pslverr = 1'b0;
		if (psel && penable && !s.b.pready) begin
			n.b.pready = 1'b1;
			n.b.prdata = '0;
			unique case (paddr)
				A_CFG: n.b.prdata = {16'h0000, s.cfg};
				A_CMD, A_LACK: n.b.prdata = '0;
				A_STAT: begin
					n.b.prdata = {21'h000000, s.expired, s.decel_pend, s.lwarn, s.o.fault_state,
						s.flt, s.o.drive_off, s.o.warn_led, 1'b0};
					n.b.pslverr = pwrite;
				end
				A_LCNT: begin
					n.b.prdata = {23'h000000, s.lcnt};
					n.b.pslverr = pwrite;
				end
				A_LIDX: n.b.prdata = {23'h000000, s.lidx};
				A_LDAT: begin
					// entries cannot be edited or erased from the bus
					n.b.prdata = {16'h0000, log_mem[wrap_add(s.ltail, s.lidx)]};
					n.b.pslverr = pwrite || (s.lidx >= s.lcnt);
				end
				default: begin
					n.b.pslverr = 1'b1;
					for (int g = 0; g < NGRP; g++) begin
						if (grp_hit(paddr, g)) begin
							n.b.pslverr = 1'b0;
							n.b.prdata = {29'h00000000, s.grp[g]};
						end
					end
				end
			endcase
		end
		// writes land only at the completing edge, when pready is seen high;
		// a refused write has already raised pslverr and changes nothing
		if (psel && penable && s.b.pready && pwrite && !s.b.pslverr) begin
			unique case (paddr)
				A_CFG: n.cfg = fwm_cfg_t'(pwdata[15:0]);
				A_CMD: cmd_rst = pwdata[CMD_RST_BIT];
				A_LIDX: n.lidx = pwdata[8:0];
				A_LACK: lack = pwdata[0];
				default: begin
					for (int g = 0; g < NGRP; g++) begin
						if (grp_hit(paddr, g)) begin
							n.grp[g] = pwdata[NWARN-1:0];
						end
					end
				end
			endcase
		end
		// external error detection
		if (s.cfg.ext_fault_source != 2'd0) begin
			ext_det = ext_in[s.cfg.ext_fault_source - 2'd1] ^ s.cfg.ext_level_low;
		end
		unique case (s.cfg.ext_fault_response)
			EXT_IGNORE: warn[W_EXT] = ext_det;
			EXT_FREEWHEEL: fset[F_EXT] = ext_det;
			EXT_CFG_STOP: begin
				n.o.stop_req = ext_det;
				warn[W_EXT] = ext_det;
			end
			EXT_DECEL: begin
				// once the fault is latched the drive is off; a lasting error must not
				// start a fresh ramp that would relatch the fault after a manual reset
				if (ext_det && !s.flt[F_EXT]) begin
					n.decel_pend = 1'b1;
				end
				if (s.decel_pend && decel_done) begin
					fset[F_EXT] = 1'b1;
					n.decel_pend = 1'b0;
				end
			end
		endcase
		if (s.cfg.ext_fault_response != EXT_DECEL) begin
			n.decel_pend = 1'b0;
		end
		// control supply
		sup_bad = !supply_ok;
		if (sup_bad) begin
			if (s.cfg.supply_loss_response == SUP_WARNING && grouped[W_SUP] && !motor_running) begin
				warn[W_SUP] = 1'b1;
			end else begin
				fset[F_SUP] = 1'b1;
			end
		end
		fset[F_OVL] = overload_in;
		fset[F_GEN] = gen_fault_in;
		cause = {gen_fault_in, overload_in, sup_bad, ext_det};
		// fault time limit, counted from the fault entry
		lim = limit_sec(s.cfg.auto_reset_time_limit);
		faulted = |s.flt;
		if (!faulted) begin
			n.tick = '0;
			n.sec = '0;
			n.expired = 1'b0;
		end else begin
			if (s.tick >= 25'(TICK_CYCLES - 1)) begin
				n.tick = '0;
				if (s.sec != 14'h3FFF) begin
					n.sec = s.sec + 14'd1;
				end
			end else begin
				n.tick = s.tick + 25'd1;
			end
			if (lim != 14'd0 && s.sec >= lim) begin
				n.expired = 1'b1;
			end
		end
		// automatic reset once every latched cause has gone
		if (s.cfg.auto_reset_enable && !s.expired && faulted && !(|(s.flt & cause))) begin
			n.flt = '0;
			n.o.restart = !s.cfg.three_wire;
		end
		// manual reset
		n.rst_di_q = reset_di;
		n.run_q = run_order;
		unique case (s.cfg.manual_reset_source)
			RST_DI: man_rst = reset_di && !s.rst_di_q;
			RST_CMD: man_rst = cmd_rst;
			RST_NONE: man_rst = run_order && !s.run_q;
			default: man_rst = 1'b0;
		endcase
		if (man_rst) begin
			n.flt = n.flt & (4'b0001 << F_OVL);
		end
		// a new cause sets its fault after any clear, so it is never lost
		n.flt = n.flt | fset;
		// security log
		if (lack) begin
			n.lwarn = 1'b0;
		end
		if (sec_evt_valid) begin
			log_we = 1'b1;
			log_wdata = {s.cfg.access_ctrl ? sec_evt_user : ADMIN_ID, sec_evt_code};
			n.lhead = wrap_add(s.lhead, 9'd1);
			if (s.lcnt == LOG_DEPTH) begin
				// full: oldest fifty go, the new one takes a slot
				n.ltail = wrap_add(s.ltail, LOG_DROP);
				n.lcnt = LOG_DEPTH - LOG_DROP + 9'd1;
			end else begin
				n.lcnt = s.lcnt + 9'd1;
			end
			if (n.lcnt == LOG_WARN_LVL) begin
				n.lwarn = 1'b1;
			end
		end
		warn[W_LOG] = s.lwarn;
		// warning groups and indicator
		for (int g = 0; g < NGRP; g++) begin
			n.o.warn_relay[g] = |(warn & s.grp[g]);
		end
		n.o.warn_led = |(warn & grouped);
		// fault outputs
		n.o.drive_off = |n.flt;
		n.o.decel_req = n.decel_pend;
		// held back while attempts run and the limit has not passed
		n.o.fault_state = (|n.flt) && !(s.cfg.auto_reset_enable && !n.expired);
		sup_only = (n.flt == (4'b0001 << F_SUP));
		n.o.fault_relay = !(s.cfg.relay_fault_map && n.o.fault_state &&
			!(sup_only && s.cfg.supply_loss_response == SUP_ERR_NO_RELAY));
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= ST_RST;
		end else begin
			s <= n;
		end
	end

	// log storage has no reset; only the counters define what is valid
	always_ff @(posedge ref_clk) begin
		if (log_we) begin
			log_mem[s.lhead] <= log_wdata;
		end
	end

	assign prdata = s.b.prdata;
	assign pready = s.b.pready;
	assign pslverr = s.b.pslverr;
	assign drive_off = s.o.drive_off;
	assign stop_req = s.o.stop_req;
	assign decel_req = s.o.decel_req;
	assign fault_state_out = s.o.fault_state;
	assign fault_relay = s.o.fault_relay;
	assign warn_relay = s.o.warn_relay;
	assign warn_led = s.o.warn_led;
	assign restart_pulse = s.o.restart;
endmodule

//--- tb/fwm_monitor.sv
// checker for the fault and warning manager, watching top ports only
// bound into fwm_top from the testbench file
`timescale 1ns/1ps
module fwm_monitor import fwm_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// fault and warning outputs
	input wire logic drive_off,
	input wire logic fault_state_out,
	input wire logic fault_relay,
	input wire logic [NGRP-1:0] warn_relay,
	input wire logic warn_led,
	input wire logic restart_pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_data_hold: assert property (!pready |-> $stable(prdata))
		else $error("prdata moved outside an answer");
	a_led_group: assert property (warn_led == (|warn_relay))
		else $error("warning led and group relays disagree");
	a_relay_fault: assert property (!fault_relay |-> drive_off)
		else $error("fault relay open with no fault");
	a_fstate_fault: assert property (fault_state_out |-> drive_off)
		else $error("fault state without fault");
	a_restart_clean: assert property (restart_pulse |-> !fault_state_out ##1 !restart_pulse)
		else $error("bad restart pulse");
endmodule

//--- tb/fwm_partner.sv
// stop sequencer model: motor state and end of deceleration
// a slow ramp is used so the fault must wait for it
`timescale 1ns/1ps
module fwm_partner #(
	parameter int DECEL_CYC = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// run order from the bench and requests from the block
	input wire logic run_order,
	input wire logic drive_off,
	input wire logic stop_req,
	input wire logic decel_req,
	// motor status
	output logic motor_running,
	output logic decel_done
);
	logic [7:0] cnt_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			motor_running <= 1'b0;
			decel_done <= 1'b0;
		end else begin
			motor_running <= run_order & ~drive_off & ~stop_req;
			cnt_q <= decel_req ? cnt_q + 8'h01 : 8'h00;
			decel_done <= decel_req && (cnt_q >= 8'(DECEL_CYC));
		end
	end
endmodule

//--- tb/testbench.sv
// bench for the fault and warning manager: apb master and scoreboard
// second tick shortened to 4 cycles, so 5 minutes is 1200 cycles
`timescale 1ns/1ps
module testbench import fwm_pkg::*;;
	logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, reset_di = 0;
	logic run_order = 0, supply_ok = 1, overload_in = 0, gen_fault_in = 0, sec_evt_valid = 0;
	logic [7:0] paddr = '0, sec_evt_code = '0, sec_evt_user = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [2:0] ext_in = '0;
	logic pready, pslverr, drive_off, stop_req, decel_req, fault_state_out, fault_relay;
	logic warn_led, restart_pulse, motor_running, decel_done;
	logic [NGRP-1:0] warn_relay;
	logic [33:0] exq[$];
	logic [15:0] evs[0:500];
	int err_total = 0, num_checks = 0, cyc = 0, rs = 0;
	always #25 ref_clk = ~ref_clk;
	fwm_top #(.TICK_CYCLES(4)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_in(ext_in), .reset_di(reset_di),
		.run_order(run_order), .motor_running(motor_running), .decel_done(decel_done),
		.supply_ok(supply_ok), .overload_in(overload_in), .gen_fault_in(gen_fault_in),
		.sec_evt_valid(sec_evt_valid), .sec_evt_code(sec_evt_code),
		.sec_evt_user(sec_evt_user), .drive_off(drive_off), .stop_req(stop_req),
		.decel_req(decel_req), .fault_state_out(fault_state_out), .fault_relay(fault_relay),
		.warn_relay(warn_relay), .warn_led(warn_led), .restart_pulse(restart_pulse));
	fwm_partner u_part (.ref_clk(ref_clk), .rst_b(rst_b), .run_order(run_order),
		.drive_off(drive_off), .stop_req(stop_req), .decel_req(decel_req),
		.motor_running(motor_running), .decel_done(decel_done));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cw(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// read: d is the expected data; er marks an expected refusal
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		exq.push_back({w, er, d});
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 0; penable <= 0;
	endtask
	task automatic pulse_reset(input logic di);
		if (di) reset_di <= 1; else run_order <= 1;
		cw(2); reset_di <= 0; run_order <= 0; cw(6);
	endtask
	always @(posedge ref_clk) begin
		logic [33:0] x;
		cyc++;
		if (restart_pulse === 1'b1) rs++;
		if (pready === 1'b1 && exq.size() > 0) begin
			x = exq.pop_front();
			chk("pslverr", 32'(x[32]), 32'(pslverr));
			if (!x[33] && !x[32]) chk("prdata", x[31:0], prdata);
		end
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		int b;
		void'($urandom(32'hC40349D3));
		cw(12); rst_b <= 1;
		apb(0, A_CFG, 32'h4008, 0);
		apb(0, 8'h30, 0, 1);
		apb(1, A_STAT, 1, 1);
		apb(1, A_GRP0, 1, 0);
		apb(1, 8'h10, 2, 0);
		for (int r = 0; r < 4; r++) begin
			apb(1, A_CFG, 32'h4001 | (r << 3), 0);
			ext_in <= 3'b001; cw(6);
			chk("drive_off", r == 1, drive_off);
			chk("stop_req", r == 2, stop_req);
			chk("decel_req", r == 3, decel_req);
			chk("warn_relay", (r == 0 || r == 2) ? 1 : 0, warn_relay);
			chk("warn_led", r == 0 || r == 2, warn_led);
			cw(30); chk("drive_off", r & 1, drive_off);
			ext_in <= 0; cw(4); pulse_reset(0); chk("drive_off", 0, drive_off);
		end
		apb(1, A_CFG, 32'h400E, 0); ext_in <= 3'b101; cw(6); chk("drive_off", 1, drive_off);
		ext_in <= 3'b111; cw(4); pulse_reset(0);
		apb(1, A_CFG, 32'h4008, 0); cw(6); chk("drive_off", 0, drive_off);
		ext_in <= 0;
		for (int w = 0; w < 2; w++) begin
			apb(1, A_CFG, 32'h4208 | (w << 13), 0);
			overload_in <= 1; cw(2); overload_in <= 0; cw(6); pulse_reset(1);
			chk("drive_off", 1, drive_off);
			b = rs; apb(1, A_CFG, 32'h4228 | (w << 13), 0); cw(8);
			chk("drive_off", 0, drive_off);
			chk("restarts", 1 - w, rs - b);
		end
		for (int s = 0; s < 3; s++) begin
			apb(1, A_CFG, 32'h4208 | (s << 11), 0); supply_ok <= 0; cw(6);
			chk("drive_off", s != 2, drive_off);
			chk("fault_relay", s != 0, fault_relay);
			chk("warn_relay", (s == 2) ? 2 : 0, warn_relay);
			supply_ok <= 1; cw(4); pulse_reset(1); chk("drive_off", 0, drive_off);
		end
		apb(1, A_CFG, 32'h4408, 0); gen_fault_in <= 1; cw(2); gen_fault_in <= 0; cw(4);
		apb(1, A_CMD, 32'h80, 0); cw(6); chk("drive_off", 0, drive_off);
		for (int t = 0; t < 8; t++) begin
			apb(1, A_CFG, 32'h4028 | (t << 6), 0); apb(0, A_CFG, 32'h4028 | (t << 6), 0);
		end
		apb(1, A_CFG, 32'h4228, 0); gen_fault_in <= 1; cw(1100);
		chk("fault_state", 0, fault_state_out);
		chk("fault_relay", 1, fault_relay);
		cw(200); chk("fault_state", 1, fault_state_out);
		chk("fault_relay", 0, fault_relay);
		gen_fault_in <= 0; cw(20); chk("drive_off", 1, drive_off);
		pulse_reset(1); chk("drive_off", 0, drive_off);
		apb(1, A_CFG, 32'h41A8, 0); gen_fault_in <= 1; cw(1400);
		chk("fault_state", 0, fault_state_out);
		gen_fault_in <= 0; cw(8); chk("drive_off", 0, drive_off);
		apb(1, A_CFG, 32'h4008, 0);
		for (int i = 0; i < 501; i++) begin
			if (i == 500) begin
				sec_evt_valid <= 0;
				apb(0, A_LCNT, 500, 0); apb(0, A_STAT, 32'h100, 0);
				apb(1, A_LACK, 1, 0); apb(0, A_STAT, 0, 0);
			end
			evs[i] = {ADMIN_ID, 8'($urandom)};
			sec_evt_code <= evs[i][7:0]; sec_evt_user <= 8'($urandom); sec_evt_valid <= 1;
			@(posedge ref_clk);
		end
		sec_evt_valid <= 0;
		apb(0, A_LCNT, 451, 0); apb(1, A_LIDX, 0, 0);
		apb(0, A_LDAT, 32'(evs[50]), 0);
		apb(1, A_LIDX, 451, 0); apb(0, A_LDAT, 0, 1); apb(1, A_LDAT, 0, 1);
		cw(4); close_out();
	end
endmodule
bind fwm_top fwm_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.drive_off(drive_off), .fault_state_out(fault_state_out), .fault_relay(fault_relay),
	.warn_relay(warn_relay), .warn_led(warn_led), .restart_pulse(restart_pulse));
